// file: design/gpio_port.v
// four-pin general-purpose port with pull-up and open-drain control
// assumes an AHB-Lite master on ref_clk_i; pins synchronised inside
// Behaviour
// RULE1: output data register holds four readable writable bits, cleared at reset.
// RULE2: all port registers keep contents through manual reset and software standby.
// RULE3: upper four bits reserved; writes ignored.
// RULE4: pin-level register is read-only; writes to it are ignored.
// RULE5: pin-level read gives output data when direction 1, pin level else.
// RULE6: after reset or hardware standby pin-level read shows pin levels.
// RULE7: pull-up on only when direction 0 and pull-up bit 1.
// RULE8: pull-ups work in modes 1,2,3,6,7; off in modes 4 and 5.
// RULE9: pull-up control clears to zero at reset or hardware standby.
// RULE10: open-drain bit 1 gives NMOS open drain, 0 gives CMOS drive.
// RULE11: open-drain bits honoured in modes 1, 2, 3 and 7.
// RULE12: open-drain control clears to zero at reset or hardware standby.
// RULE13: modes 1,2,3,7: direction 1 drives output data, 0 is input.
// RULE14: modes 4 and 5: all pins carry low address outputs.
// RULE15: mode 6: direction 1 drives address output, 0 is input.
// RULE16: direction register write-only, cleared at reset or hardware standby.
// RULE17: software standby: address pins hold or float, chosen by hold bit.
// RULE18: writes take effect next clock edge; reserved bits read zero.
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module gpio_port (
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    input  wire        clk_en_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    input  wire [2:0]  op_mode_i,
    input  wire        hw_standby_i,
    input  wire        sw_standby_i,
    input  wire        standby_output_hold_i,
    input  wire [3:0]  addr_bus_i,
    input  wire [3:0]  io_pin_i,
    output wire [3:0]  io_pin_o,
    output wire [3:0]  io_pin_oe_n_o,
    output wire [3:0]  pullup_en_o
);
    reg  [3:0]  dir_q;
    reg  [3:0]  out_q;
    reg  [3:0]  pullup_q;
    reg  [3:0]  open_drain_q;
    reg  [11:0] addr_q;
    reg         wr_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg  [3:0]  dir_d;
    reg  [3:0]  out_d;
    reg  [3:0]  pullup_d;
    reg  [3:0]  open_drain_d;
    reg  [3:0]  pin_out_q;
    reg  [3:0]  pin_oe_n_q;
    reg  [3:0]  pull_q;
    wire [3:0]  pin_out_d;
    wire [3:0]  pin_oe_n_d;
    wire [3:0]  pull_d;
    wire [3:0]  level_view;
    wire [3:0]  io_drive;
    wire [3:0]  addr_drive;
    wire        addr_float;
    wire        wr_dir;
    wire        wr_out;
    wire        wr_pullup;
    wire        wr_open_drain;
    reg         hw_meta_q;
    reg         hw_sync_q;
    reg         sw_meta_q;
    reg         sw_sync_q;
    wire [3:0]  pin_sync_w;
    wire        take;
    wire        mode_io;
    wire        mode_addr_all;
    wire        mode_addr_dir;
    wire        pull_mode;
    genvar      g;

    pin_sync u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   (io_pin_i),
        .sync_o    (pin_sync_w)
    );

    // standby levels come from the chip's mode logic off this clock
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hw_meta_q <= 1'b0;
            hw_sync_q <= 1'b0;
            sw_meta_q <= 1'b0;
            sw_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            hw_meta_q <= hw_standby_i;
            hw_sync_q <= hw_meta_q;
            sw_meta_q <= sw_standby_i;
            sw_sync_q <= sw_meta_q;
        end
    end

    assign mode_io = (op_mode_i == `MODE_1) || (op_mode_i == `MODE_2) ||
                     (op_mode_i == `MODE_3) || (op_mode_i == `MODE_7);
    assign mode_addr_all = (op_mode_i == `MODE_4) ||
                           (op_mode_i == `MODE_5);
    assign mode_addr_dir = (op_mode_i == `MODE_6);
    assign pull_mode = mode_io || mode_addr_dir; // RULE8

    // address phase capture
    assign take = hsel_i && hready_i && htrans_i[1];

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_q <= 12'h000;
            wr_q   <= 1'b0;
        end else if (clk_en_i && hready_i) begin
            addr_q <= haddr_i[11:0];
            wr_q   <= take && hwrite_i;
        end
    end

    // write strobes in the data phase; pin-level offset has none
    assign wr_dir        = wr_q && (addr_q == `OFS_DIRECTION); // RULE3 RULE18
    assign wr_out        = wr_q && (addr_q == `OFS_OUTPUT_DATA); // RULE4
    assign wr_pullup     = wr_q && (addr_q == `OFS_PULLUP_CONTROL);
    assign wr_open_drain = wr_q && (addr_q == `OFS_OPEN_DRAIN_CTRL);

    // next contents; only bits 3..0 stored
    always @* begin
        dir_d        = dir_q; // RULE2
        out_d        = out_q;
        pullup_d     = pullup_q;
        open_drain_d = open_drain_q;
        if (hw_sync_q) begin
            dir_d        = `PORT_RESET; // RULE16
            out_d        = `PORT_RESET; // RULE1
            pullup_d     = `PORT_RESET; // RULE9
            open_drain_d = `PORT_RESET; // RULE12
        end else begin
            if (wr_dir) begin
                dir_d = hwdata_i[`PORT_BITS_MSB:0];
            end
            if (wr_out) begin
                out_d = hwdata_i[`PORT_BITS_MSB:0];
            end
            if (wr_pullup) begin
                pullup_d = hwdata_i[`PORT_BITS_MSB:0];
            end
            if (wr_open_drain) begin
                open_drain_d = hwdata_i[`PORT_BITS_MSB:0];
            end
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_q        <= `PORT_RESET; // RULE16
            out_q        <= `PORT_RESET; // RULE1
            pullup_q     <= `PORT_RESET; // RULE9
            open_drain_q <= `PORT_RESET; // RULE12
        end else if (clk_en_i) begin
            dir_q        <= dir_d;
            out_q        <= out_d;
            pullup_q     <= pullup_d;
            open_drain_q <= open_drain_d;
        end
    end

    // read data, registered at the address phase from next contents
    // so that a read right behind a write sees the new value
    always @* begin
        rdata_d = 32'h0000_0000; // RULE18
        case (haddr_i[11:0])
            `OFS_OUTPUT_DATA:     rdata_d[3:0] = out_d;
            `OFS_PIN_LEVEL:       rdata_d[3:0] = level_view;
            `OFS_PULLUP_CONTROL:  rdata_d[3:0] = pullup_d;
            `OFS_OPEN_DRAIN_CTRL: rdata_d[3:0] = open_drain_d;
            `OFS_PORT_STATE: begin
                rdata_d[`STATE_MODE_MSB:`STATE_MODE_LSB] = op_mode_i;
                rdata_d[`STATE_SWSTBY_BIT] = sw_sync_q;
                rdata_d[`STATE_HWSTBY_BIT] = hw_sync_q;
                rdata_d[`STATE_HOLD_BIT]   = standby_output_hold_i;
            end
            default: rdata_d = 32'h0000_0000; // RULE16
        endcase
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en_i && take && !hwrite_i) begin
            rdata_q <= rdata_d;
        end
    end

    // pin drive per bit; oe_n low means the pin is driven
    assign addr_float = sw_sync_q && !standby_output_hold_i; // RULE17

    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_bit
            // read view: output data where direction bit is 1, pin level else
            assign level_view[g] = dir_d[g] ? out_d[g] // RULE5 RULE6
                                 : pin_sync_w[g];
            assign io_drive[g]   = mode_io && dir_q[g]; // RULE13
            assign addr_drive[g] = mode_addr_all || // RULE14 RULE15
                                   (mode_addr_dir && dir_q[g]);
            assign pin_out_d[g]  = io_drive[g]   ? out_q[g]      :
                                   addr_drive[g] ? addr_bus_i[g] : 1'b0;
            // open drain only sinks a low; address pins ignore it
            assign pin_oe_n_d[g] = hw_sync_q ? 1'b1 :
                                   io_drive[g] ? // RULE10 RULE11
                                       (open_drain_q[g] && out_q[g]) :
                                   addr_drive[g] ? addr_float : 1'b1;
            assign pull_d[g]     = !hw_sync_q && pull_mode && // RULE7
                                   !dir_q[g] && pullup_q[g];
        end
    endgenerate

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_q  <= 4'h0;
            pin_oe_n_q <= 4'hf;
            pull_q     <= 4'h0;
        end else if (clk_en_i) begin
            // in software standby with hold, address pins keep state
            if (!(sw_sync_q && standby_output_hold_i)) begin // RULE17
                pin_out_q <= pin_out_d;
            end
            pin_oe_n_q <= pin_oe_n_d;
            pull_q     <= pull_d;
        end
    end

    assign io_pin_o      = pin_out_q;
    assign io_pin_oe_n_o = pin_oe_n_q;
    assign pullup_en_o   = pull_q;
    assign hrdata_o      = rdata_q;
    assign hreadyout_o   = 1'b1;
    assign hresp_o       = 1'b0;
endmodule

// file: design/gpio_port_defines.vh
// constants of the four-pin port: register offsets, fields, resets, modes
// assumes one aligned 32-bit word per register on an AHB-Lite slave
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define OFS_DIRECTION       12'h000
`define OFS_OUTPUT_DATA     12'h004
`define OFS_PIN_LEVEL       12'h008
`define OFS_PULLUP_CONTROL  12'h00c
`define OFS_OPEN_DRAIN_CTRL 12'h010
`define OFS_PORT_STATE      12'h014

`define PORT_BITS_MSB       3
`define PORT_RESET          4'h0

`define STATE_MODE_LSB      0
`define STATE_MODE_MSB      2
`define STATE_SWSTBY_BIT    3
`define STATE_HWSTBY_BIT    4
`define STATE_HOLD_BIT      5

`define MODE_1              3'h1
`define MODE_2              3'h2
`define MODE_3              3'h3
`define MODE_4              3'h4
`define MODE_5              3'h5
`define MODE_6              3'h6
`define MODE_7              3'h7

`define HTRANS_NONSEQ       2'h2
`define HTRANS_SEQ          2'h3

`endif

// file: design/pin_sync.v
// two-flop synchroniser for the four pin levels
// assumes the pins are asynchronous to ref_clk_i
`timescale 1ns/100ps
module pin_sync (
    input  wire       ref_clk_i,
    input  wire       arst_n_i,
    input  wire       clk_en_i,
    input  wire [3:0] async_i,
    output wire [3:0] sync_o
);
    reg [3:0] meta_q;
    reg [3:0] sync_q;

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else if (clk_en_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// file: tb/gpio_port_chk.sv
// assertions on the four-pin port, seen from its top-level ports
// assumes it is bound to gpio_port by the testbench
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module gpio_port_chk (
    input logic        ref_clk_i,
    input logic        arst_n_i,
    input logic        clk_en_i,
    input logic        hsel_i,
    input logic [31:0] haddr_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic        hready_i,
    input logic [31:0] hrdata_o,
    input logic        hreadyout_o,
    input logic        hresp_o,
    input logic [2:0]  op_mode_i,
    input logic        hw_standby_i,
    input logic        sw_standby_i,
    input logic [3:0]  addr_bus_i,
    input logic [3:0]  io_pin_o,
    input logic [3:0]  io_pin_oe_n_o,
    input logic [3:0]  pullup_en_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire m45 = op_mode_i == `MODE_4 || op_mode_i == `MODE_5;
    wire m6  = op_mode_i == `MODE_6;
    // mode held long enough to pass the standby synchronisers
    sequence steady(m);
        (m && clk_en_i && !hw_standby_i && !sw_standby_i)[*4];
    endsequence
    sequence rd(a);
        hsel_i && hready_i && htrans_i[1] && !hwrite_i && clk_en_i &&
            haddr_i[11:0] == a;
    endsequence
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    a_reset_pins: assert property ($rose(arst_n_i) |->
        io_pin_oe_n_o == 4'hf && pullup_en_o == 4'h0 && io_pin_o == 4'h0)
        else $error("pins not released after reset");
    a_hw_float: assert property ((hw_standby_i && clk_en_i)[*4] |->
        io_pin_oe_n_o == 4'hf && pullup_en_o == 4'h0)
        else $error("pins not released in hardware standby");
    a_addr_follow: assert property (steady(m45) |->
        io_pin_o == $past(addr_bus_i) && io_pin_oe_n_o == 4'h0)
        else $error("address not on pins in modes 4 and 5");
    a_no_pull45: assert property (steady(m45) |-> pullup_en_o == 4'h0)
        else $error("pull-up on in modes 4 and 5");
    a_mode6_addr: assert property (steady(m6) |->
        ((io_pin_o ^ $past(addr_bus_i)) & ~io_pin_oe_n_o) == 4'h0)
        else $error("driven pin differs from address in mode 6");
    a_pull_input: assert property ((pullup_en_o & ~io_pin_oe_n_o) == 4'h0)
        else $error("pull-up on a driven pin");
    a_dir_read: assert property (rd(`OFS_DIRECTION) |=> hrdata_o == 0)
        else $error("direction read not zero");
    a_upper_zero: assert property (rd(`OFS_OUTPUT_DATA) |=>
        hrdata_o[31:4] == 28'h0)
        else $error("reserved read bits not zero");
endmodule

// file: tb/port_board.sv
// board model on the four port pins
// assumes the board drives lines the device releases unless hiz_i marks them
`timescale 1ns/100ps
module port_board (
    input  logic       ref_clk_i,
    input  logic [3:0] io_pin_o,
    input  logic [3:0] io_pin_oe_n_o,
    input  logic [3:0] pullup_en_o,
    input  logic [3:0] drive_i,
    input  logic [3:0] hiz_i,
    output logic [3:0] io_pin_i
);
    logic tog_q = 1'b0;
    always @(posedge ref_clk_i)
        tog_q <= ~tog_q;
    // device, else board, else pull-up, else a toggling floating level
    always_comb
        for (int i = 0; i < 4; i++)
            io_pin_i[i] = !io_pin_oe_n_o[i] ? io_pin_o[i] :
                !hiz_i[i] ? drive_i[i] : pullup_en_o[i] | tog_q;
endmodule

// file: tb/test_gpio_port.sv
// testbench of the four-pin port: bus tasks, board model, checker
// assumes zero wait states on the bus and a 40 MHz clock
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module test_gpio_port;
    logic        ref_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, hready;
    logic        hw_stby = 0, sw_stby = 0, hold = 0, en = 1, hresp;
    logic [1:0]  htrans = 0;
    logic [2:0]  mode = `MODE_1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [3:0]  abus = 4'h9, drv = 4'ha, hiz = 0, pin_i, pin_o, oe_n, pu;
    int          err_total = 0, samples_checked = 0, m;
    always #12.5 ref_clk = ~ref_clk;
    gpio_port u_dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
        .clk_en_i(en), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .op_mode_i(mode), .hw_standby_i(hw_stby),
        .sw_standby_i(sw_stby), .standby_output_hold_i(hold),
        .addr_bus_i(abus), .io_pin_i(pin_i), .io_pin_o(pin_o),
        .io_pin_oe_n_o(oe_n), .pullup_en_o(pu));
    port_board u_board (.ref_clk_i(ref_clk), .io_pin_o(pin_o),
        .io_pin_oe_n_o(oe_n), .pullup_en_o(pu), .drive_i(drv),
        .hiz_i(hiz), .io_pin_i(pin_i));
    task summarize;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input string n, input logic [11:0] a, input logic [3:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, {28'h0, e}, rd);
    endtask
    task settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    // driven level, enables and pull-ups in one word
    task pins(input logic [3:0] o, input logic [3:0] oe, input logic [3:0] p);
        settle;
        chk("pins", {20'h0, o & ~oe, oe, p}, {20'h0, pin_o & ~oe_n, oe_n, pu});
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        arst_n <= 1'b1;
        settle;
        pins(4'h0, 4'hf, 4'h0);
        rdchk("out data", `OFS_OUTPUT_DATA, 4'h0);
        rdchk("pull-up", `OFS_PULLUP_CONTROL, 4'h0);
        rdchk("open drain", `OFS_OPEN_DRAIN_CTRL, 4'h0);
        rdchk("pin level", `OFS_PIN_LEVEL, 4'ha);
        bus(1'b1, `OFS_OUTPUT_DATA, 32'hffff_fff5);
        rdchk("out data", `OFS_OUTPUT_DATA, 4'h5);
        bus(1'b1, `OFS_PIN_LEVEL, 32'h9);
        rdchk("out data", `OFS_OUTPUT_DATA, 4'h5);
        // clock enable low: a write must not land
        @(posedge ref_clk);
        en <= 1'b0;
        bus(1'b1, `OFS_OUTPUT_DATA, 32'ha);
        en <= 1'b1;
        rdchk("frozen out", `OFS_OUTPUT_DATA, 4'h5);
        bus(1'b1, `OFS_DIRECTION, 32'h3);
        rdchk("direction", `OFS_DIRECTION, 4'h0);
        pins(4'h1, 4'hc, 4'h0);
        rdchk("pin level", `OFS_PIN_LEVEL, 4'h9);
        bus(1'b1, `OFS_PULLUP_CONTROL, 32'hf);
        hiz <= 4'hc;
        settle;
        rdchk("pin level", `OFS_PIN_LEVEL, 4'hd);
        for (m = 1; m < 8; m++) begin
            @(posedge ref_clk);
            mode <= m[2:0];
            abus <= {1'b1, m[2:0]};
            pins((m > 3 && m < 7) ? {1'b1, m[2:0]} : 4'h1,
                (m == 4 || m == 5) ? 4'h0 : 4'hc,
                (m == 4 || m == 5) ? 4'h0 : 4'hc);
        end
        @(posedge ref_clk);
        mode <= `MODE_1;
        bus(1'b1, `OFS_OPEN_DRAIN_CTRL, 32'h3);
        pins(4'h0, 4'hd, 4'hc);
        @(posedge ref_clk);
        sw_stby <= 1'b1;
        hold <= 1'b1;
        settle;
        rdchk("out data", `OFS_OUTPUT_DATA, 4'h5);
        rdchk("pull-up", `OFS_PULLUP_CONTROL, 4'hf);
        // state word: hold, hw standby, sw standby, mode
        bus(1'b0, `OFS_PORT_STATE, 32'h0);
        chk("state", {26'h0, 3'h5, `MODE_1}, rd);
        // address pins float in software standby without hold
        @(posedge ref_clk);
        hold <= 1'b0;
        mode <= `MODE_4;
        pins(4'h0, 4'hf, 4'h0);
        @(posedge ref_clk);
        sw_stby <= 1'b0;
        hw_stby <= 1'b1;
        hiz <= 4'h0;
        mode <= `MODE_1;
        pins(4'h0, 4'hf, 4'h0);
        @(posedge ref_clk);
        hw_stby <= 1'b0;
        settle;
        rdchk("out data", `OFS_OUTPUT_DATA, 4'h0);
        rdchk("pull-up", `OFS_PULLUP_CONTROL, 4'h0);
        rdchk("open drain", `OFS_OPEN_DRAIN_CTRL, 4'h0);
        rdchk("pin level", `OFS_PIN_LEVEL, 4'ha);
        summarize;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        summarize;
    end
endmodule
bind gpio_port gpio_port_chk u_chk (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .op_mode_i(op_mode_i), .hw_standby_i(hw_standby_i),
    .sw_standby_i(sw_standby_i), .addr_bus_i(addr_bus_i),
    .io_pin_o(io_pin_o), .io_pin_oe_n_o(io_pin_oe_n_o),
    .pullup_en_o(pullup_en_o));
